//--- led_fault_cfg.svh
`ifndef LED_FAULT_CFG_SVH
`define LED_FAULT_CFG_SVH
`define CLK_FREQ_HZ          20000000
`define CHANNELS             10
`define SHORT_CHECK_NS       10000
`define SHORT_CHECK_CYCLES   ((`SHORT_CHECK_NS * 20 + 999) / 1000)
`define RECHECK_NS           5000
`define RECHECK_CYCLES       ((`RECHECK_NS * 20 + 999) / 1000)
`endif

//--- led_fault_pkg.sv
`default_nettype none
package led_fault_pkg;
    typedef enum logic [2:0] {
        ST_STARTUP_CHECK,
        ST_STARTUP_FAULT,
        ST_RUN,
        ST_OVP_DRAIN,
        ST_OVP_RECHECK,
        ST_SHORT_SHUTDOWN,
        ST_LATCHED
    } fault_state_t;
endpackage : led_fault_pkg
`default_nettype wire

//--- pin_sync.sv
`default_nettype none
module pin_sync (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_pin,
    output logic      o_level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_t;

    sync_t r;
    sync_t next_r;

    // Level changes only once second and third stage agree
    always_comb begin
        next_r    = r;
        next_r.s1 = i_pin;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3) begin
            next_r.level = r.s3;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_level = r.level;
endmodule : pin_sync
`default_nettype wire

//--- led_driver_fault_response.sv
`include "led_fault_cfg.svh"
`default_nettype none
// Notes on behaviour
// (R1) Frequency-set pin overcurrent: boost and sinks off, flag on, auto restart.
// (R2) Primary switch limit truncates current cycle only; no flag.
// (R3) After primary limit, next cycle switches normally; nothing shut down.
// (R4) Secondary switch limit: disconnect, sinks, boost off, flag, latched.
// (R5) Only power or enable cycling clears latched shutdown.
// (R6) Overvoltage with all strings regulated: boost stops, flag set, auto.
// (R7) During that overvoltage the LED sinks stay active to drain output.
// (R8) Boost resumes once output falls below the hysteresis level.
// (R9) Overvoltage with unregulated string runs the short recheck.
// (R10) Unregulated channel shorted: boost off forever, flag, short bit set.
// (R11) Not shorted: drop channel, release flag, set regulation-lost bit.
// (R12) At power-up every LED pin is tested for ground short first; the code tests only channels set in i_channel_enable.
// (R13) Startup short: boost, sinks off, flag on, retry, disconnect on.
// (R14) Overtemperature: boost, sinks off, flag, disconnect on, auto restart.
// (R15) Open-diode overvoltage latches all off with flag until cycled.
module led_driver_fault_response
    import led_fault_pkg::*;
#(
    parameter int N = `CHANNELS
) (
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_enable,
    input  wire logic         i_freq_set_short,
    input  wire logic         i_cycle_start,
    input  wire logic         i_switch_cycle_limit,
    input  wire logic         i_switch_hard_limit,
    input  wire logic         i_overvoltage_trip,
    input  wire logic         i_overvoltage_release,
    input  wire logic         i_backup_overvoltage,
    input  wire logic         i_thermal_shutdown,
    input  wire logic [N-1:0] i_channel_enable,
    input  wire logic [N-1:0] i_channel_in_reg,
    input  wire logic [N-1:0] i_channel_grounded,
    output logic              o_boost_enable,
    output logic              o_boost_gate_allow,
    output logic              o_sinks_enable,
    output logic              o_disconnect_on,
    output logic              o_fault_n_out,
    output logic              o_fault_n_oe,
    output logic [N-1:0]      o_active_channels,
    output logic [N-1:0]      o_short_status,
    output logic [N-1:0]      o_lost_reg_status
);
    localparam logic [15:0] SC_CYC = 16'(`SHORT_CHECK_CYCLES);
    localparam logic [15:0] RC_CYC = 16'(`RECHECK_CYCLES);

    // Comparator inputs are asynchronous to the core clock
    logic en_s, fset_s, cyc_lim_s, hard_s, ovp_s, ovp_rel_s, bkp_s, tsd_s;
    pin_sync u_en   (.i_clk(i_clk), .i_nrst(i_nrst), .i_pin(i_enable),              .o_level(en_s));
    pin_sync u_fset (.i_clk(i_clk), .i_nrst(i_nrst), .i_pin(i_freq_set_short),      .o_level(fset_s));
    pin_sync u_lim  (.i_clk(i_clk), .i_nrst(i_nrst), .i_pin(i_switch_cycle_limit),  .o_level(cyc_lim_s));
    pin_sync u_hard (.i_clk(i_clk), .i_nrst(i_nrst), .i_pin(i_switch_hard_limit),   .o_level(hard_s));
    pin_sync u_ovp  (.i_clk(i_clk), .i_nrst(i_nrst), .i_pin(i_overvoltage_trip),    .o_level(ovp_s));
    pin_sync u_ovr  (.i_clk(i_clk), .i_nrst(i_nrst), .i_pin(i_overvoltage_release), .o_level(ovp_rel_s));
    pin_sync u_bkp  (.i_clk(i_clk), .i_nrst(i_nrst), .i_pin(i_backup_overvoltage),  .o_level(bkp_s));
    pin_sync u_tsd  (.i_clk(i_clk), .i_nrst(i_nrst), .i_pin(i_thermal_shutdown),    .o_level(tsd_s));

    typedef struct packed {
        fault_state_t st;
        logic [15:0]  cnt;
        logic         truncate;
        logic         boost;
        logic         gate;
        logic         sinks;
        logic         disc;
        logic         flag;
        logic [N-1:0] active;
        logic [N-1:0] shorted;
        logic [N-1:0] lost;
    } core_t;

    core_t r;
    core_t next_r;
    logic [N-1:0] unreg;

    always_comb begin
        next_r = r;
        unreg  = r.active & i_channel_enable & ~i_channel_in_reg;
        // Truncation holds to the end of the cycle, then clears
        if (cyc_lim_s) begin
            next_r.truncate = 1'b1; // R2
        end else if (i_cycle_start) begin
            next_r.truncate = 1'b0; // R3
        end
        case (r.st)
            ST_STARTUP_CHECK: begin
                next_r.boost = 1'b0;
                next_r.sinks = 1'b0;
                next_r.disc  = 1'b1;
                next_r.flag  = 1'b0;
                if (r.cnt < SC_CYC) begin
                    next_r.cnt = r.cnt + 16'h0001;
                end else if ((i_channel_enable & i_channel_grounded) != '0) begin
                    next_r.st   = ST_STARTUP_FAULT; // R12
                    next_r.flag = 1'b1; // R13
                    next_r.cnt  = 16'h0000;
                end else begin
                    next_r.st    = ST_RUN;
                    next_r.boost = 1'b1;
                    next_r.sinks = 1'b1;
                end
            end
            ST_STARTUP_FAULT: begin
                // Retry keeps disconnect on; the startup check releases the flag again
                next_r.st  = ST_STARTUP_CHECK; // R13
                next_r.cnt = 16'h0000;
            end
            ST_RUN: begin
                next_r.boost = ~fset_s & ~tsd_s; // R1 R14
                next_r.sinks = ~fset_s & ~tsd_s; // R1 R14
                next_r.flag  = fset_s | tsd_s; // R1 R14
                next_r.disc  = 1'b1;
                if (ovp_s) begin
                    if (unreg != '0) begin
                        next_r.st    = ST_OVP_RECHECK; // R9
                        next_r.boost = 1'b0;
                        next_r.flag  = 1'b1;
                        next_r.cnt   = 16'h0000;
                    end else begin
                        next_r.st    = ST_OVP_DRAIN; // R6
                        next_r.boost = 1'b0;
                        next_r.flag  = 1'b1;
                        next_r.sinks = 1'b1; // R7
                    end
                end
            end
            ST_OVP_DRAIN: begin
                next_r.sinks = 1'b1; // R7
                if (ovp_rel_s && !ovp_s) begin
                    next_r.st    = ST_RUN; // R8
                    next_r.boost = 1'b1;
                    next_r.flag  = 1'b0;
                end
            end
            ST_OVP_RECHECK: begin
                if (r.cnt < RC_CYC) begin
                    next_r.cnt = r.cnt + 16'h0001;
                end else if ((unreg & i_channel_grounded) != '0) begin
                    next_r.st      = ST_SHORT_SHUTDOWN; // R10
                    next_r.shorted = r.shorted | (unreg & i_channel_grounded);
                    next_r.sinks   = 1'b0;
                end else begin
                    next_r.st     = ST_RUN; // R11
                    next_r.active = r.active & ~unreg;
                    next_r.lost   = r.lost | unreg;
                    next_r.flag   = 1'b0;
                    next_r.boost  = 1'b1;
                end
            end
            ST_SHORT_SHUTDOWN: begin
                next_r.boost = 1'b0; // R10
                next_r.flag  = 1'b1;
            end
            default: begin
                next_r.boost = 1'b0; // R5
                next_r.sinks = 1'b0;
                next_r.disc  = 1'b0;
                next_r.flag  = 1'b1;
            end
        endcase
        // Hard faults override every state and latch
        if (hard_s || bkp_s) begin
            next_r.st    = ST_LATCHED; // R4 R15
            next_r.boost = 1'b0;
            next_r.sinks = 1'b0;
            next_r.disc  = 1'b0;
            next_r.flag  = 1'b1;
        end
        // Enable toggle is the only way out besides power cycling
        if (!en_s) begin
            next_r.st      = ST_STARTUP_CHECK; // R5
            next_r.cnt     = 16'h0000;
            next_r.boost   = 1'b0;
            next_r.sinks   = 1'b0;
            next_r.disc    = 1'b0;
            next_r.flag    = 1'b0;
            next_r.active  = '1;
            next_r.shorted = '0;
            next_r.lost    = '0;
        end
        next_r.gate = next_r.boost & ~next_r.truncate; // R2
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            r.st       <= ST_STARTUP_CHECK;
            r.cnt      <= 16'h0000;
            r.truncate <= 1'b0;
            r.boost    <= 1'b0;
            r.gate     <= 1'b0;
            r.sinks    <= 1'b0;
            r.disc     <= 1'b0;
            r.flag     <= 1'b0;
            r.active   <= '1;
            r.shorted  <= '0;
            r.lost     <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_boost_enable     = r.boost;
    assign o_boost_gate_allow = r.gate;
    assign o_sinks_enable     = r.sinks;
    assign o_disconnect_on    = r.disc;
    assign o_fault_n_out      = 1'b0;
    assign o_fault_n_oe       = r.flag;
    assign o_active_channels  = r.active;
    assign o_short_status     = r.shorted;
    assign o_lost_reg_status  = r.lost;

    // Multi-step flows start from these; each excludes the overriding faults
    sequence limit_in_run_s;
        r.st == ST_RUN && cyc_lim_s && !fset_s && !tsd_s && !ovp_s && en_s && !hard_s && !bkp_s;
    endsequence
    sequence ovp_regulated_s;
        r.st == ST_RUN && ovp_s && unreg == '0 && en_s && !hard_s && !bkp_s;
    endsequence
    sequence ovp_unregulated_s;
        r.st == ST_RUN && ovp_s && unreg != '0 && en_s && !hard_s && !bkp_s;
    endsequence
    sequence drain_release_s;
        r.st == ST_OVP_DRAIN && ovp_rel_s && !ovp_s && en_s && !hard_s && !bkp_s;
    endsequence
    sequence recheck_short_s;
        r.st == ST_OVP_RECHECK && r.cnt >= RC_CYC && (unreg & i_channel_grounded) != '0
            && en_s && !hard_s && !bkp_s;
    endsequence
    sequence recheck_open_s;
        r.st == ST_OVP_RECHECK && r.cnt >= RC_CYC && (unreg & i_channel_grounded) == '0
            && en_s && !hard_s && !bkp_s;
    endsequence
    sequence startup_short_s;
        r.st == ST_STARTUP_CHECK && r.cnt >= SC_CYC && (i_channel_enable & i_channel_grounded) != '0
            && en_s && !hard_s && !bkp_s;
    endsequence

    latch_holds_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
        (r.st == ST_LATCHED && en_s) |=> (r.st == ST_LATCHED))
        else $error("latched shutdown left without enable cycle");
    hard_limit_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R4
        (hard_s && en_s) |=> (!o_disconnect_on && !o_boost_enable && o_fault_n_oe))
        else $error("hard limit did not shut down");
    backup_ovp_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R15
        (bkp_s && en_s) |=> (!o_sinks_enable && !o_disconnect_on && !o_boost_enable && o_fault_n_oe))
        else $error("backup overvoltage did not latch off");
    fset_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
        (r.st == ST_RUN && fset_s && en_s && !ovp_s && !hard_s && !bkp_s)
        |=> (!o_boost_enable && !o_sinks_enable && o_disconnect_on && o_fault_n_oe))
        else $error("frequency-set short response wrong");
    tsd_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R14
        (r.st == ST_RUN && tsd_s && en_s && !ovp_s && !hard_s && !bkp_s)
        |=> (!o_boost_enable && !o_sinks_enable && o_disconnect_on && o_fault_n_oe))
        else $error("overtemperature response wrong");
    drain_sinks_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R7
        (r.st == ST_OVP_DRAIN) |-> (o_sinks_enable && !o_boost_enable))
        else $error("sinks off while draining");
    truncate_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R2
        r.truncate |-> !o_boost_gate_allow)
        else $error("gate allowed during truncated cycle");
    short_stays_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R10
        (r.st == ST_SHORT_SHUTDOWN && en_s && !hard_s && !bkp_s) |=> !o_boost_enable [*2])
        else $error("boost restarted after short");
    startup_check_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R12
        (r.st == ST_STARTUP_CHECK) |-> !o_boost_enable)
        else $error("boost on before short check");

    limit_truncates_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R2
        cyc_lim_s |=> !o_boost_gate_allow)
        else $error("switch limit did not truncate the cycle");
    limit_no_stop_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R3
        limit_in_run_s |=> (o_boost_enable && o_sinks_enable && o_disconnect_on && !o_fault_n_oe))
        else $error("switch limit shut the converter down");
    ovp_drain_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R6
        ovp_regulated_s |=> (r.st == ST_OVP_DRAIN && !o_boost_enable && o_sinks_enable && o_fault_n_oe))
        else $error("overvoltage drain entry wrong");
    ovp_resume_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R8
        drain_release_s |=> (r.st == ST_RUN && o_boost_enable && !o_fault_n_oe))
        else $error("boost did not resume below hysteresis level");
    ovp_recheck_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R9
        ovp_unregulated_s |=> (r.st == ST_OVP_RECHECK && !o_boost_enable && o_fault_n_oe))
        else $error("unregulated overvoltage skipped the recheck");
    recheck_short_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R10
        recheck_short_s |=> (r.st == ST_SHORT_SHUTDOWN && !o_boost_enable && !o_sinks_enable
            && o_fault_n_oe && o_short_status != '0))
        else $error("shorted channel did not shut down");
    recheck_drop_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R11
        recheck_open_s |=> (r.st == ST_RUN && o_boost_enable && !o_fault_n_oe
            && (o_active_channels & $past(unreg)) == '0 && (o_lost_reg_status & $past(unreg)) == $past(unreg)))
        else $error("open channel not dropped");
    startup_short_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R13
        startup_short_s |=> (r.st == ST_STARTUP_FAULT && o_fault_n_oe && o_disconnect_on
            && !o_boost_enable && !o_sinks_enable))
        else $error("startup short response wrong");
    enable_restart_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
        !en_s |=> (r.st == ST_STARTUP_CHECK && !o_boost_enable
            && o_short_status == '0 && o_lost_reg_status == '0))
        else $error("enable low did not restart");
endmodule : led_driver_fault_response
`default_nettype wire

//--- host_flag_monitor.sv
`default_nettype none
module host_flag_monitor (
    input  wire logic i_clk,
    input  wire logic i_fault_n_out,
    input  wire logic i_fault_n_oe,
    input  wire logic i_restart,
    output logic      o_enable,
    output logic      o_flag,
    output int        o_flag_count
);
    timeunit 1ns;
    timeprecision 100ps;
    logic line;
    logic prev;
    int   hold;
    // Pull-up: released line reads high
    assign line   = i_fault_n_oe ? i_fault_n_out : 1'b1;
    assign o_flag = ~line;
    initial begin
        o_enable     = 1'b1;
        o_flag_count = 0;
        prev         = 1'b0;
        hold         = 0;
    end
    always @(posedge i_clk) begin
        if (o_flag && !prev) begin
            o_flag_count <= o_flag_count + 1;
        end
        prev <= o_flag;
        // Low long enough to pass the input synchroniser
        if (i_restart) begin
            hold     <= 8;
            o_enable <= #2 1'b0;
        end else if (hold == 1) begin
            hold     <= 0;
            o_enable <= #2 1'b1;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
    end
endmodule : host_flag_monitor
`default_nettype wire

//--- led_driver_fault_response_bench.sv
`default_nettype none
module led_driver_fault_response_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 0, i_nrst = 0, i_freq_set_short = 0, i_cycle_start = 0;
    logic i_switch_cycle_limit = 0, i_switch_hard_limit = 0, i_overvoltage_trip = 0;
    logic i_overvoltage_release = 1, i_backup_overvoltage = 0, i_thermal_shutdown = 0;
    logic [9:0] i_channel_enable = 10'h3ff, i_channel_in_reg = 10'h3ff, i_channel_grounded = 10'h000;
    logic o_boost_enable, o_boost_gate_allow, o_sinks_enable, o_disconnect_on;
    logic o_fault_n_out, o_fault_n_oe, enable, flag, restart = 0;
    logic [9:0] o_active_channels, o_short_status, o_lost_reg_status;
    int fails = 0, cmp_count = 0, flag_count, c;
    always #25 i_clk = ~i_clk;
    led_driver_fault_response led_driver_fault_response_inst (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_enable(enable), .i_freq_set_short(i_freq_set_short), .i_cycle_start(i_cycle_start),
        .i_switch_cycle_limit(i_switch_cycle_limit), .i_switch_hard_limit(i_switch_hard_limit),
        .i_overvoltage_trip(i_overvoltage_trip), .i_overvoltage_release(i_overvoltage_release),
        .i_backup_overvoltage(i_backup_overvoltage), .i_thermal_shutdown(i_thermal_shutdown),
        .i_channel_enable(i_channel_enable), .i_channel_in_reg(i_channel_in_reg),
        .i_channel_grounded(i_channel_grounded), .o_boost_enable(o_boost_enable),
        .o_boost_gate_allow(o_boost_gate_allow), .o_sinks_enable(o_sinks_enable),
        .o_disconnect_on(o_disconnect_on), .o_fault_n_out(o_fault_n_out), .o_fault_n_oe(o_fault_n_oe),
        .o_active_channels(o_active_channels), .o_short_status(o_short_status),
        .o_lost_reg_status(o_lost_reg_status));
    host_flag_monitor host_flag_monitor_inst (.i_clk(i_clk), .i_fault_n_out(o_fault_n_out),
        .i_fault_n_oe(o_fault_n_oe), .i_restart(restart), .o_enable(enable), .o_flag(flag),
        .o_flag_count(flag_count));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : tick
    // Boost, sinks, disconnect, flag
    task automatic st(input logic [3:0] e);
        chk({o_boost_enable, o_sinks_enable, o_disconnect_on, flag}, e);
    endtask : st
    task automatic wait_boost();
        int k;
        k = 0;
        while (o_boost_enable !== 1'b1 && k < 600) begin
            tick(1);
            k++;
        end
        st(4'b1110);
    endtask : wait_boost
    task automatic t_startup();
        tick(100);
        chk(o_boost_enable, 0);
        wait_boost();
        $display("startup done");
    endtask : t_startup
    task automatic t_auto(input int w);
        if (w == 0) i_freq_set_short = 1; else i_thermal_shutdown = 1;
        tick(8);
        st(4'b0011);
        i_freq_set_short = 0;
        i_thermal_shutdown = 0;
        wait_boost();
        $display("auto restart %0d done", w);
    endtask : t_auto
    task automatic t_cycle();
        i_switch_cycle_limit = 1;
        tick(8);
        chk({o_boost_gate_allow, o_boost_enable, o_sinks_enable, o_disconnect_on, flag}, 5'b01110);
        i_switch_cycle_limit = 0;
        tick(8);
        chk(o_boost_gate_allow, 0);
        i_cycle_start = 1;
        tick(1);
        i_cycle_start = 0;
        tick(1);
        st(4'b1110);
        chk(o_boost_gate_allow, 1);
        $display("cycle limit done");
    endtask : t_cycle
    task automatic t_ovp_ok();
        i_overvoltage_release = 0;
        i_overvoltage_trip = 1;
        tick(8);
        st(4'b0111);
        i_overvoltage_trip = 0;
        tick(8);
        chk(o_boost_enable, 0);
        i_overvoltage_release = 1;
        tick(8);
        st(4'b1110);
        $display("overvoltage done");
    endtask : t_ovp_ok
    task automatic t_ovp_open();
        i_channel_in_reg[3] = 0;
        i_overvoltage_release = 0;
        i_overvoltage_trip = 1;
        tick(10);
        i_overvoltage_trip = 0;
        tick(140);
        chk({o_active_channels[3], o_lost_reg_status[3], o_short_status}, 12'h400);
        i_overvoltage_release = 1;
        wait_boost();
        i_channel_in_reg[3] = 1;
        $display("open channel done");
    endtask : t_ovp_open
    task automatic t_reset();
        i_nrst = 0;
        tick(2);
        st(4'b0000);
        chk({o_active_channels, o_lost_reg_status}, 20'hffc00);
        i_nrst = 1;
        wait_boost();
        $display("mid-run reset done");
    endtask : t_reset
    task automatic t_latch(input int w);
        if (w == 0) i_switch_hard_limit = 1; else i_backup_overvoltage = 1;
        tick(8);
        st(4'b0001);
        i_switch_hard_limit = 0;
        i_backup_overvoltage = 0;
        tick(20);
        st(4'b0001);
        restart = 1;
        tick(1);
        restart = 0;
        wait_boost();
        $display("latched %0d done", w);
    endtask : t_latch
    task automatic t_short();
        i_channel_in_reg[5] = 0;
        i_channel_grounded[5] = 1;
        i_overvoltage_release = 0;
        i_overvoltage_trip = 1;
        tick(10);
        i_overvoltage_trip = 0;
        tick(140);
        chk({o_short_status[5], o_boost_enable, flag}, 3'b101);
        i_overvoltage_release = 1;
        tick(50);
        chk(o_boost_enable, 0);
        restart = 1;
        tick(1);
        restart = 0;
        c = flag_count;
        tick(500);
        chk({o_boost_enable, o_sinks_enable, o_disconnect_on}, 3'b001);
        chk(flag_count - c >= 2, 1);
        i_channel_grounded[5] = 0;
        i_channel_in_reg[5] = 1;
        wait_boost();
        $display("ground short done");
    endtask : t_short
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial begin
        tick(20000);
        fails++;
        final_report();
    end
    initial begin
        tick(6);
        i_nrst = 1;
        t_startup();
        t_auto(0);
        t_auto(1);
        t_cycle();
        t_ovp_ok();
        t_ovp_open();
        t_reset();
        t_latch(0);
        t_latch(1);
        t_short();
        final_report();
    end
endmodule : led_driver_fault_response_bench
`default_nettype wire
